/* File: common/rmsl_regs.svh */
`ifndef RMSL_REGS_SVH
`define RMSL_REGS_SVH
// ------------------------------------------------------------
// Register offsets (word index on the register port)
// ------------------------------------------------------------
`define RMSL_OFS_COMMAND 20'h00000
`define RMSL_OFS_TIMEOUT 20'h480da
`define RMSL_OFS_MEMSIZE 20'h02710
`define RMSL_OFS_CHENABLE 20'h02af8
`define RMSL_OFS_STATUS 20'h0000a
// ------------------------------------------------------------
// Command codes and status values
// ------------------------------------------------------------
`define RMSL_CMD_START_WAIT 32'h0000000b
`define RMSL_CMD_HALT 32'h00000014
`define RMSL_STAT_RUN 32'h00000000
`define RMSL_STAT_READY 32'h00000014
// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define RMSL_TIMEOUT_RST 32'h00000000
`define RMSL_MEMSIZE_RST 32'h00000040
`define RMSL_CHEN_RST 4'h1
`define RMSL_MS_NS 1000000
`define RMSL_CLK_NS 10
`define RMSL_CYC_PER_MS (`RMSL_MS_NS / `RMSL_CLK_NS)
// Channel enable patterns
`define RMSL_CHEN_ONE 4'h1
`define RMSL_CHEN_01 4'h3
`define RMSL_CHEN_02 4'h5
`define RMSL_CHEN_ALL 4'hf
`endif

/* File: common/rmsl_pkg.sv */
package rmsl_pkg;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [19:0] addr;
    logic [31:0] wdata;
  } rmsl_req_t;
  // One converter output frame: four channels of 8 bit
  typedef struct packed {
    logic [3:0] valid;
    logic [7:0] ch3;
    logic [7:0] ch2;
    logic [7:0] ch1;
    logic [7:0] ch0;
  } rmsl_out_t;
  typedef enum logic [1:0] {
    RMSL_IDLE,
    RMSL_RUN
  } rmsl_state_t;
endpackage : rmsl_pkg

/* File: src/rmsl_mem.sv */
`timescale 1ns/1ps
// Two memory channels of 16 bit words, one write port, one read port each
module rmsl_mem #(
  parameter int DEPTH = 1024
) (
  input wire logic i_clock,
  input wire logic i_wr,
  input wire logic i_wr_mch,
  input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic [$clog2(DEPTH)-1:0] i_rd_addr0,
  input wire logic [$clog2(DEPTH)-1:0] i_rd_addr1,
  output logic [15:0] o_rd_data0,
  output logic [15:0] o_rd_data1
);
  initial begin
    if (DEPTH < 2) $error("rmsl_mem: DEPTH too small");
  end
  logic [15:0] mem0 [DEPTH];
  logic [15:0] mem1 [DEPTH];
  // ------------------------------------------------------------
  // Writes address each memory channel on its own
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_wr && !i_wr_mch) mem0[i_wr_addr] <= i_wr_data;
    if (i_wr && i_wr_mch) mem1[i_wr_addr] <= i_wr_data;
  end
  // Registered reads, one cycle latency
  always_ff @(posedge i_clock) begin
    o_rd_data0 <= mem0[i_rd_addr0];
    o_rd_data1 <= mem1[i_rd_addr1];
  end
endmodule : rmsl_mem

/* File: src/rmsl_top.sv */
`timescale 1ns/1ps
`include "rmsl_regs.svh"
module rmsl_top #(
  parameter int DEPTH = 1024,
  parameter int CYC_PER_MS = `RMSL_CYC_PER_MS
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire rmsl_pkg::rmsl_req_t i_req,
  input wire logic i_trigger,
  input wire logic i_ext_clk_ok,
  input wire logic i_dwr,
  input wire logic i_dwr_mch,
  input wire logic [31:0] i_dwr_start,
  input wire logic [15:0] i_dwr_data,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic o_irq,
  output logic o_timeout,
  output logic o_running,
  output rmsl_pkg::rmsl_out_t o_out
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 64 || (DEPTH & (DEPTH - 1)) != 0) $error("rmsl_top: DEPTH must be power of two >= 64");
    if (CYC_PER_MS < 1) $error("rmsl_top: CYC_PER_MS must be positive");
  end

  // ------------------------------------------------------------
  // Input synchronisers for pin level inputs
  // ------------------------------------------------------------
  logic [1:0] trig_sync;
  logic [1:0] clkok_sync;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      trig_sync <= 2'h0;
      clkok_sync <= 2'h0;
    end else begin
      trig_sync <= {trig_sync[0], i_trigger};
      clkok_sync <= {clkok_sync[0], i_ext_clk_ok};
    end
  end
  logic trig_q;
  logic armed;
  always_ff @(posedge i_clock) begin
    if (i_rst) trig_q <= 1'b0;
    else trig_q <= trig_sync[1];
  end
  wire trig_edge = trig_sync[1] && !trig_q;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] timeout_ms;
  logic [31:0] memsize;
  logic [3:0] chen;
  rmsl_pkg::rmsl_state_t state;
  wire cmd_wr = i_req.wr && i_req.addr == `RMSL_OFS_COMMAND;
  wire cmd_start = cmd_wr && i_req.wdata == `RMSL_CMD_START_WAIT;
  wire cmd_halt = cmd_wr && i_req.wdata == `RMSL_CMD_HALT;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      timeout_ms <= `RMSL_TIMEOUT_RST;
      memsize <= `RMSL_MEMSIZE_RST;
      chen <= `RMSL_CHEN_RST;
    end else if (i_req.wr && state == rmsl_pkg::RMSL_IDLE) begin
      // Settings are frozen while running so replay stays coherent
      if (i_req.addr == `RMSL_OFS_TIMEOUT) timeout_ms <= i_req.wdata;
      if (i_req.addr == `RMSL_OFS_MEMSIZE) memsize <= i_req.wdata;
      if (i_req.addr == `RMSL_OFS_CHENABLE) chen <= i_req.wdata[3:0];
    end
  end
  // Read answer one cycle after the strobe; unmapped reads zero
  // Data is loaded only on a read, so it holds until the next one
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
      if (i_req.rd) begin
        case (i_req.addr)
          `RMSL_OFS_COMMAND: o_rdata <= {28'h0, chen & 4'h0};
          `RMSL_OFS_TIMEOUT: o_rdata <= timeout_ms;
          `RMSL_OFS_MEMSIZE: o_rdata <= memsize;
          `RMSL_OFS_CHENABLE: o_rdata <= {28'h0, chen};
          `RMSL_OFS_STATUS: o_rdata <= (state == rmsl_pkg::RMSL_RUN) ? `RMSL_STAT_RUN : `RMSL_STAT_READY;
          default: o_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Channels per memory channel and replay length in words
  // ------------------------------------------------------------
  function automatic logic [1:0] per_mch(input logic [3:0] en);
    case (en)
      `RMSL_CHEN_01: per_mch = 2'd2;
      `RMSL_CHEN_ALL: per_mch = 2'd2;
      default: per_mch = 2'd1;
    endcase
  endfunction : per_mch
  wire [1:0] mult = per_mch(chen);
  wire [AW:0] words = (AW + 1)'(memsize * mult);

  // ------------------------------------------------------------
  // Run control, timeout and completion
  // ------------------------------------------------------------
  logic [31:0] ms_left;
  logic [31:0] ms_tick;
  logic [AW:0] rd_ptr;
  logic replay_done;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= rmsl_pkg::RMSL_IDLE;
      o_irq <= 1'b0;
      o_timeout <= 1'b0;
      armed <= 1'b0;
      ms_left <= 32'h0;
      ms_tick <= 32'h0;
    end else begin
      o_irq <= 1'b0;
      case (state)
        rmsl_pkg::RMSL_IDLE: begin
          if (cmd_start) begin
            state <= rmsl_pkg::RMSL_RUN;
            o_timeout <= 1'b0;
            armed <= 1'b0;
            ms_left <= timeout_ms;
            ms_tick <= 32'h0;
          end
        end
        rmsl_pkg::RMSL_RUN: begin
          if (trig_edge && clkok_sync[1]) armed <= 1'b1;
          if (ms_tick == 32'(CYC_PER_MS - 1)) begin
            ms_tick <= 32'h0;
            if (ms_left != 32'h0) ms_left <= ms_left - 32'h1;
          end else begin
            ms_tick <= ms_tick + 32'h1;
          end
          if (cmd_halt) begin
            state <= rmsl_pkg::RMSL_IDLE;
            o_irq <= 1'b1;
          end else if (timeout_ms != 32'h0 && ms_left == 32'h1 && ms_tick == 32'(CYC_PER_MS - 1)) begin
            state <= rmsl_pkg::RMSL_IDLE;
            o_timeout <= 1'b1;
            o_irq <= 1'b1;
          end else if (replay_done) begin
            state <= rmsl_pkg::RMSL_IDLE;
            o_irq <= 1'b1;
          end
        end
        default: state <= rmsl_pkg::RMSL_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) o_running <= 1'b0;
    else o_running <= (state == rmsl_pkg::RMSL_RUN);
  end

  // ------------------------------------------------------------
  // Replay: one pass of the region after trigger, external clock present
  // ------------------------------------------------------------
  wire step = state == rmsl_pkg::RMSL_RUN && armed && clkok_sync[1];
  assign replay_done = step && (rd_ptr >= words - (AW + 1)'(mult));
  always_ff @(posedge i_clock) begin
    if (i_rst || state == rmsl_pkg::RMSL_IDLE) rd_ptr <= '0;
    else if (step) rd_ptr <= rd_ptr + (AW + 1)'(mult);
  end
  wire [AW-1:0] a0 = rd_ptr[AW-1:0];
  wire [AW-1:0] a1 = rd_ptr[AW-1:0] + AW'(1);
  logic [15:0] m0_lo;
  logic [15:0] m0_hi;
  logic [15:0] m1_lo;
  logic [15:0] m1_hi;
  // Two instances give the paired read an interleaved channel needs
  rmsl_mem #(.DEPTH(DEPTH)) u_mem_lo (
    .i_clock(i_clock),
    .i_wr(i_dwr),
    .i_wr_mch(i_dwr_mch),
    .i_wr_addr(i_dwr_start[AW-1:0]),
    .i_wr_data(i_dwr_data),
    .i_rd_addr0(a0),
    .i_rd_addr1(a0),
    .o_rd_data0(m0_lo),
    .o_rd_data1(m1_lo)
  );
  rmsl_mem #(.DEPTH(DEPTH)) u_mem_hi (
    .i_clock(i_clock),
    .i_wr(i_dwr),
    .i_wr_mch(i_dwr_mch),
    .i_wr_addr(i_dwr_start[AW-1:0]),
    .i_wr_data(i_dwr_data),
    .i_rd_addr0(a1),
    .i_rd_addr1(a1),
    .o_rd_data0(m0_hi),
    .o_rd_data1(m1_hi)
  );
  logic step_q;
  always_ff @(posedge i_clock) begin
    if (i_rst) step_q <= 1'b0;
    else step_q <= step;
  end
  // Low byte goes to the converter bit for bit; upper byte unused
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_out <= '0;
    end else begin
      o_out.valid <= step_q ? chen : 4'h0;
      case (chen)
        `RMSL_CHEN_01: begin
          o_out.ch0 <= m0_lo[7:0];
          o_out.ch1 <= m0_hi[7:0];
        end
        `RMSL_CHEN_02: begin
          o_out.ch0 <= m0_lo[7:0];
          o_out.ch2 <= m1_lo[7:0];
        end
        `RMSL_CHEN_ALL: begin
          o_out.ch0 <= m0_lo[7:0];
          o_out.ch1 <= m0_hi[7:0];
          o_out.ch2 <= m1_lo[7:0];
          o_out.ch3 <= m1_hi[7:0];
        end
        default: o_out.ch0 <= m0_lo[7:0];
      endcase
    end
  end
endmodule : rmsl_top

/* File: testbench/rmsl_top_sva.sv */
`timescale 1ns/1ps
`include "rmsl_regs.svh"
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module rmsl_chk #(
  parameter int DEPTH = 1024,
  parameter int CYC_PER_MS = `RMSL_CYC_PER_MS
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire rmsl_pkg::rmsl_req_t i_req,
  input wire logic i_trigger,
  input wire logic i_ext_clk_ok,
  input wire logic i_dwr,
  input wire logic i_dwr_mch,
  input wire logic [31:0] i_dwr_start,
  input wire logic [15:0] i_dwr_data,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_irq,
  input wire logic o_timeout,
  input wire logic o_running,
  input wire rmsl_pkg::rmsl_out_t o_out
);
  logic tmo_zero;
  logic trig_seen;
  logic halt_wr;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  assign halt_wr = i_req.wr && i_req.addr == `RMSL_OFS_COMMAND && i_req.wdata == `RMSL_CMD_HALT;
  // Writes while running are refused, so only idle writes count
  always_ff @(posedge i_clock) begin
    if (i_rst) tmo_zero <= 1'b1;
    else if (i_req.wr && i_req.addr == `RMSL_OFS_TIMEOUT && !o_running) tmo_zero <= (i_req.wdata == 32'h0);
  end
  // Any usable trigger level since the last command write may end a run
  always_ff @(posedge i_clock) begin
    if (i_rst) trig_seen <= 1'b0;
    else if (i_trigger && i_ext_clk_ok) trig_seen <= 1'b1;
    else if (i_req.wr && i_req.addr == `RMSL_OFS_COMMAND) trig_seen <= 1'b0;
  end
  sequence s_cmd(logic [31:0] code);
    i_req.wr && i_req.addr == `RMSL_OFS_COMMAND && i_req.wdata == code;
  endsequence
  sequence s_other_cmd;
    i_req.wr && i_req.addr == `RMSL_OFS_COMMAND && i_req.wdata != `RMSL_CMD_START_WAIT && !halt_wr;
  endsequence
  a_start_runs: assert property (s_cmd(`RMSL_CMD_START_WAIT) ##1 !i_req.wr |-> ##1 o_running)
    else $error("start command did not set running");
  a_halt_stops: assert property (s_cmd(`RMSL_CMD_HALT) ##0 o_running |=> o_irq ##1 !o_running)
    else $error("halt did not stop with interrupt");
  a_cmd_ignored: assert property (s_other_cmd ##0 (!o_running && !$past(i_req.wr)) ##1 !i_req.wr |-> ##1 !o_running)
    else $error("unknown command changed run state");
  a_read_answer: assert property (i_req.rd |=> o_rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (o_rvalid |-> $past(i_req.rd))
    else $error("answer without read");
  a_irq_single: assert property (o_irq |=> !o_irq)
    else $error("interrupt longer than one cycle");
  a_timeout_irq: assert property ($rose(o_timeout) |-> o_irq)
    else $error("timeout without interrupt");
  a_no_self_stop: assert property (o_running && tmo_zero && !trig_seen && !halt_wr && !$past(halt_wr) |=> o_running)
    else $error("device stopped by itself");
endmodule : rmsl_chk
bind rmsl_top rmsl_chk #(.DEPTH(DEPTH), .CYC_PER_MS(CYC_PER_MS)) rmsl_chk_inst (.i_clock(i_clock), .i_rst(i_rst),
  .i_req(i_req), .i_trigger(i_trigger), .i_ext_clk_ok(i_ext_clk_ok), .i_dwr(i_dwr), .i_dwr_mch(i_dwr_mch),
  .i_dwr_start(i_dwr_start), .i_dwr_data(i_dwr_data), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_irq(o_irq),
  .o_timeout(o_timeout), .o_running(o_running), .o_out(o_out));

/* File: testbench/rmsl_host.sv */
`timescale 1ns/1ps
`include "rmsl_regs.svh"
// ------------------------------------------------------------
// Host driver model
// ------------------------------------------------------------
module rmsl_host (
  input wire logic i_clock,
  input wire logic [31:0] i_rdata,
  input wire logic i_irq,
  input wire logic i_timeout,
  output rmsl_pkg::rmsl_req_t o_req
);
  initial o_req = '0;
  // One strobe cycle; idle lines inverted so stale values never match
  task automatic access(input logic wr, input logic [19:0] addr, input logic [31:0] wdata);
    @(posedge i_clock);
    #1;
    o_req = {wr, !wr, addr, wdata};
    @(posedge i_clock);
    #1;
    o_req = {2'b00, ~addr, ~wdata};
  endtask : access
  // Answer is registered at the taking edge
  task automatic read(input logic [19:0] addr, output logic [31:0] data);
    access(1'b0, addr, 32'h0);
    data = i_rdata;
  endtask : read
  // Blocks until the device reports stopped, no polling
  task automatic start_wait(output logic err);
    access(1'b1, `RMSL_OFS_COMMAND, `RMSL_CMD_START_WAIT);
    do begin
      @(posedge i_clock);
      #1;
    end while (i_irq !== 1'b1);
    err = i_timeout;
  endtask : start_wait
endmodule : rmsl_host

/* File: testbench/rmsl_top_tb.sv */
`timescale 1ns/1ps
`include "rmsl_regs.svh"
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module rmsl_top_tb;
  localparam int CPM = 10;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  rmsl_pkg::rmsl_req_t i_req;
  logic i_trigger = 1'b0;
  logic i_ext_clk_ok = 1'b1;
  logic i_dwr = 1'b0;
  logic i_dwr_mch = 1'b0;
  logic [31:0] i_dwr_start = 32'h0;
  logic [15:0] i_dwr_data = 16'h0;
  logic [31:0] o_rdata;
  logic o_rvalid, o_irq, o_timeout, o_running;
  rmsl_pkg::rmsl_out_t o_out;
  int fails = 0;
  int tests_run = 0;
  logic [7:0] seen [4][$];
  logic [3:0] modes [4] = '{4'h1, 4'h3, 4'h5, 4'hf};
  always #5 i_clock = ~i_clock;
  rmsl_top #(.DEPTH(64), .CYC_PER_MS(CPM)) rmsl_top_inst (.i_clock(i_clock), .i_rst(i_rst), .i_req(i_req),
    .i_trigger(i_trigger), .i_ext_clk_ok(i_ext_clk_ok), .i_dwr(i_dwr), .i_dwr_mch(i_dwr_mch),
    .i_dwr_start(i_dwr_start), .i_dwr_data(i_dwr_data), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_irq(o_irq),
    .o_timeout(o_timeout), .o_running(o_running), .o_out(o_out));
  rmsl_host rmsl_host_inst (.i_clock(i_clock), .i_rdata(o_rdata), .i_irq(o_irq), .i_timeout(o_timeout),
    .o_req(i_req));
  // Old values are read here, before the edge's updates land
  always @(posedge i_clock) begin
    for (int c = 0; c < 4; c++) begin
      if (o_out.valid[c] === 1'b1) seen[c].push_back(o_out[8*c +: 8]);
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic rd_chk(input string what, input logic [19:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rmsl_host_inst.read(a, d);
    cmp(what, exp, d);
  endtask : rd_chk
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    rmsl_host_inst.access(1'b1, a, d);
  endtask : wr
  // High byte is junk on purpose: it must never reach a lane
  task automatic dwrite(input logic mch, input int k, input logic [7:0] s);
    @(posedge i_clock);
    #1;
    i_dwr = 1'b1;
    i_dwr_mch = mch;
    i_dwr_start = 32'(k);
    i_dwr_data = {8'h5a, s};
    @(posedge i_clock);
    #1;
    i_dwr = 1'b0;
    i_dwr_data = ~i_dwr_data;
  endtask : dwrite
  task automatic t_defaults();
    rd_chk("timeout", `RMSL_OFS_TIMEOUT, 32'h0);
    rd_chk("memsize", `RMSL_OFS_MEMSIZE, `RMSL_MEMSIZE_RST);
    rd_chk("chenable", `RMSL_OFS_CHENABLE, {28'h0, `RMSL_CHEN_RST});
    rd_chk("status", `RMSL_OFS_STATUS, `RMSL_STAT_READY);
    rd_chk("unmapped", 20'h00123, 32'h0);
  endtask : t_defaults
  task automatic t_ignored();
    wr(`RMSL_OFS_COMMAND, 32'h5);
    wr(`RMSL_OFS_COMMAND, `RMSL_CMD_START_WAIT);
    wr(`RMSL_OFS_COMMAND, 32'h0);
    wr(`RMSL_OFS_TIMEOUT, 32'h7);
    cmp("ignored", 32'h1, {31'h0, o_running});
    rd_chk("status_run", `RMSL_OFS_STATUS, `RMSL_STAT_RUN);
    rd_chk("tmo_locked", `RMSL_OFS_TIMEOUT, 32'h0);
    wr(`RMSL_OFS_COMMAND, `RMSL_CMD_HALT);
    repeat (3) @(posedge i_clock);
    // Step off the edge so the next scenario's pin changes never race the sampling flops
    #1;
  endtask : t_ignored
  // No external clock and zero limit: only the halt may end it
  task automatic t_halt();
    logic err;
    i_ext_clk_ok = 1'b0;
    fork
      rmsl_host_inst.start_wait(err);
      begin
        repeat (10) @(posedge i_clock);
        #1;
        i_trigger = 1'b1;
        repeat (40) @(posedge i_clock);
        #1;
        cmp("no_stop", 32'h1, {31'h0, o_running});
        wr(`RMSL_OFS_COMMAND, `RMSL_CMD_HALT);
      end
    join
    cmp("halt_err", 32'h0, {31'h0, err});
    rd_chk("stopped", `RMSL_OFS_STATUS, `RMSL_STAT_READY);
    i_trigger = 1'b0;
    i_ext_clk_ok = 1'b1;
  endtask : t_halt
  task automatic t_timeout();
    logic err;
    realtime t0;
    int cyc;
    wr(`RMSL_OFS_TIMEOUT, 32'h3);
    t0 = $realtime;
    rmsl_host_inst.start_wait(err);
    cyc = int'(($realtime - t0) / 10.0);
    cmp("tmo_err", 32'h1, {31'h0, err});
    cmp("tmo_len", 32'h1, {31'h0, (cyc >= 3 * CPM) && (cyc <= 3 * CPM + 8)});
    wr(`RMSL_OFS_TIMEOUT, 32'h0);
  endtask : t_timeout
  task automatic t_replay(input logic [3:0] chen);
    logic err;
    int mult;
    mult = chen[1] ? 2 : 1;
    wr(`RMSL_OFS_MEMSIZE, 32'h4);
    wr(`RMSL_OFS_CHENABLE, {28'h0, chen});
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 4 * mult; k++) dwrite(1'(m), k, 8'h80 + 8'(m * 32 + k));
    end
    for (int c = 0; c < 4; c++) seen[c].delete();
    fork
      rmsl_host_inst.start_wait(err);
      begin
        repeat (6) @(posedge i_clock);
        #1;
        i_trigger = 1'b1;
        repeat (4) @(posedge i_clock);
        #1;
        i_trigger = 1'b0;
      end
    join
    // The last frames leave the output register after the interrupt
    repeat (3) @(posedge i_clock);
    #1;
    cmp("tmo_clear", 32'h0, {31'h0, err});
    for (int c = 0; c < 4; c++) begin
      cmp("count", chen[c] ? 32'h4 : 32'h0, seen[c].size());
      for (int i = 0; i < seen[c].size() && i < 4; i++) begin
        cmp("sample", {24'h0, 8'h80 + 8'((c >> 1) * 32 + i * mult + (c & 1))}, {24'h0, seen[c][i]});
      end
    end
  endtask : t_replay
  task automatic give_verdict();
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // Watchdog, well past the expected run length
  initial begin
    repeat (4000) @(posedge i_clock);
    fails++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    t_defaults();
    t_ignored();
    t_halt();
    t_timeout();
    foreach (modes[n]) t_replay(modes[n]);
    give_verdict();
  end
endmodule : rmsl_top_tb
